// *** src/heat_regs_pkg.sv ***
package heat_regs_pkg;
  // Register space selector
  localparam logic SPACE_INPUT = 1'b0;
  localparam logic SPACE_HOLD = 1'b1;
  // Input register offsets
  localparam logic [15:0] IR_MEAS_TEMP = 16'h0001;
  localparam logic [15:0] IR_DUTY = 16'h0002;
  localparam logic [15:0] IR_ACT_SP = 16'h0003;
  localparam logic [15:0] IR_SRC_STAT = 16'h000A;
  localparam logic [15:0] IR_ROLE_STAT = 16'h000B;
  localparam logic [15:0] IR_DAYNIGHT = 16'h000C;
  localparam logic [15:0] IR_REMOTE_OFF = 16'h000D;
  localparam logic [15:0] IR_LINK_FAULT = 16'h000E;
  // Holding register offsets
  localparam logic [15:0] HR_STATION = 16'h0001;
  localparam logic [15:0] HR_BIT_RATE = 16'h0002;
  localparam logic [15:0] HR_PARITY = 16'h0003;
  localparam logic [15:0] HR_DEV_TYPE = 16'h0004;
  localparam logic [15:0] HR_HW_REV = 16'h0005;
  localparam logic [15:0] HR_FW_REV = 16'h0006;
  localparam logic [15:0] HR_BUS_CTRL = 16'h0007;
  localparam logic [15:0] HR_OVR_EN = 16'h0008;
  localparam logic [15:0] HR_DAY_SP = 16'h000B;
  localparam logic [15:0] HR_NIGHT_SP = 16'h000C;
  localparam logic [15:0] HR_ROLE_SEL = 16'h000D;
  localparam logic [15:0] HR_SRC_SEL = 16'h000E;
  localparam logic [15:0] HR_PWM_PERIOD = 16'h000F;
  localparam logic [15:0] HR_CAL_LOW = 16'h0010;
  localparam logic [15:0] HR_CAL_HIGH = 16'h0011;
  localparam logic [15:0] HR_RO_EN = 16'h0012;
  localparam logic [15:0] HR_OVR_PCT = 16'h0015;
  // Reset values
  localparam logic [15:0] RST_STATION = 16'h0001;
  localparam logic [15:0] RST_BIT_RATE = 16'h0002;
  localparam logic [15:0] RST_PARITY = 16'h0001;
  localparam logic [15:0] RST_BUS_CTRL = 16'h0000;
  localparam logic [15:0] RST_OVR_EN = 16'h0000;
  localparam logic [15:0] RST_DAY_SP = 16'h00FA;
  localparam logic [15:0] RST_NIGHT_SP = 16'h00B4;
  localparam logic [15:0] RST_ROLE_SEL = 16'h0001;
  localparam logic [15:0] RST_SRC_SEL = 16'h0001;
  localparam logic [15:0] RST_PWM_PERIOD = 16'h001E;
  localparam logic [15:0] RST_CAL_LOW = 16'h00D2;
  localparam logic [15:0] RST_CAL_HIGH = 16'h01EA;
  localparam logic [15:0] RST_RO_EN = 16'h0001;
  localparam logic [15:0] RST_OVR_PCT = 16'h0000;
  // Legal value ranges
  localparam logic [15:0] STATION_MAX = 16'h00F7;
  localparam logic [15:0] RATE_MAX = 16'h0004;
  localparam logic [15:0] PARITY_MAX = 16'h0002;
  localparam logic [15:0] PCT_MAX = 16'h0064;
  localparam logic [15:0] SP_MIN = 16'h0032;
  localparam logic [15:0] SP_MAX = 16'h012C;
  localparam logic [15:0] PWM_MAX = 16'h003C;
  localparam logic [15:0] CAL_MAX = 16'h03FF;
  localparam logic [15:0] CAL_TRIGGER = 16'h0001;
  // Bit rates and clock
  localparam int CLK_HZ = 100000000;
  localparam int BAUD_1 = 9600;
  localparam int BAUD_2 = 19200;
  localparam int BAUD_3 = 38400;
  localparam int BAUD_4 = 57600;
  localparam logic [15:0] BIT_CYC_1 = 16'(CLK_HZ / BAUD_1);
  localparam logic [15:0] BIT_CYC_2 = 16'(CLK_HZ / BAUD_2);
  localparam logic [15:0] BIT_CYC_3 = 16'(CLK_HZ / BAUD_3);
  localparam logic [15:0] BIT_CYC_4 = 16'(CLK_HZ / BAUD_4);
  // Synchronised pin indices
  localparam int PIN_NIGHT = 0;
  localparam int PIN_CONTACT = 1;
  localparam int PIN_ROLE = 2;
  localparam int PIN_SRC = 3;
  localparam logic [3:0] RST_PINS = 4'h3;
endpackage

// *** src/heating_ctrl_modbus_regs.sv ***
`timescale 1ns/10ps
module heating_ctrl_modbus_regs
  import heat_regs_pkg::*;
#(
  parameter logic [15:0] DEVICE_TYPE = 16'h0A5A, // Arbitrary value
  parameter logic [15:0] HW_REVISION = 16'h0203, // Arbitrary value
  parameter logic [15:0] FW_REVISION = 16'h0305 // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register access port from the serial slave
  input wire logic req_i,
  input wire logic space_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  // Values from the control side, same clock
  input wire logic [15:0] meas_temp_i,
  input wire logic [15:0] loop_duty_i,
  input wire logic [15:0] analog_in_pct_i,
  input wire logic [15:0] ext_setpoint_i,
  input wire logic [15:0] trim_setpoint_i,
  input wire logic board_link_fault_i,
  input wire logic cal_low_done_i,
  input wire logic [15:0] cal_low_value_i,
  input wire logic cal_high_done_i,
  input wire logic [15:0] cal_high_value_i,
  // Pins from outside the clock domain
  input wire logic night_switch_i,
  input wire logic remote_off_contact_input_i,
  input wire logic role_jumper_i,
  input wire logic source_jumper_i,
  // Link settings to the serial framer
  output logic [7:0] station_addr_o,
  output logic [2:0] bit_rate_code_o,
  output logic [15:0] bit_cycles_o,
  output logic [1:0] parity_o,
  // Control outputs
  output logic bus_mode_o,
  output logic leader_o,
  output logic internal_setpoint_source_o,
  output logic standby_o,
  output logic [15:0] active_setpoint_o,
  output logic [6:0] duty_o,
  output logic [5:0] pwm_period_s_o,
  output logic cal_low_start_o,
  output logic cal_high_start_o,
  output logic [9:0] cal_low_o,
  output logic [9:0] cal_high_o
);

  typedef struct packed {
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_flt;
    logic [15:0] station;
    logic [15:0] bit_rate;
    logic [15:0] parity;
    logic [15:0] bus_ctrl;
    logic [15:0] ovr_en;
    logic [15:0] day_sp;
    logic [15:0] night_sp;
    logic [15:0] role_sel;
    logic [15:0] src_sel;
    logic [15:0] pwm_period;
    logic [15:0] cal_low;
    logic [15:0] cal_high;
    logic [15:0] ro_en;
    logic [15:0] ovr_pct;
    logic [15:0] bit_cycles;
    logic leader;
    logic int_src;
    logic standby;
    logic fault;
    logic [15:0] act_sp;
    logic [15:0] duty;
    logic cal_low_go;
    logic cal_high_go;
    logic ack;
    logic [15:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Cycles per serial bit for a bit-rate code
  function automatic logic [15:0] bit_cycles_of(input logic [15:0] code);
    case (code)
      16'h0001: bit_cycles_of = BIT_CYC_1;
      16'h0003: bit_cycles_of = BIT_CYC_3;
      16'h0004: bit_cycles_of = BIT_CYC_4;
      default: bit_cycles_of = BIT_CYC_2;
    endcase
  endfunction

  // True when a value lies in an inclusive range
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic hold_wr;
  logic ovr_active;

  // Writes only land in the holding space
  assign hold_wr = req_i && we_i && (space_i == SPACE_HOLD);
  assign ovr_active = state_reg.bus_ctrl[0] && state_reg.ovr_en[0];

  // Next state: synchronisers, register writes, derived status, read mux
  always_comb begin
    state_next = state_reg;
    state_next.cal_low_go = 1'b0;
    state_next.cal_high_go = 1'b0;
    state_next.ack = req_i;
    state_next.rdata = 16'h0000;

    // Pin filter: a change counts once stages two and three agree
    state_next.pin_s1 = {source_jumper_i, role_jumper_i, remote_off_contact_input_i,
                         night_switch_i};
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.pin_s3 = state_reg.pin_s2;
    for (int i = 0; i < 4; i++) begin
      if (state_reg.pin_s2[i] == state_reg.pin_s3[i]) begin
        state_next.pin_flt[i] = state_reg.pin_s3[i];
      end
    end

    // Holding register writes; out-of-range values are dropped
    if (hold_wr) begin
      case (addr_i)
        HR_STATION: begin
          if (in_range(wdata_i, 16'h0001, STATION_MAX)) begin
            state_next.station = wdata_i;
          end
        end
        HR_BIT_RATE: begin
          if (in_range(wdata_i, 16'h0001, RATE_MAX)) begin
            state_next.bit_rate = wdata_i;
          end
        end
        HR_PARITY: begin
          if (wdata_i <= PARITY_MAX) begin
            state_next.parity = wdata_i;
          end
        end
        HR_BUS_CTRL: begin
          if (wdata_i <= 16'h0001) begin
            state_next.bus_ctrl = wdata_i;
          end
        end
        HR_OVR_EN: begin
          if (wdata_i <= 16'h0001) begin
            state_next.ovr_en = wdata_i;
          end
        end
        HR_DAY_SP: begin
          if (in_range(wdata_i, SP_MIN, SP_MAX)) begin
            state_next.day_sp = wdata_i;
          end
        end
        HR_NIGHT_SP: begin
          if (in_range(wdata_i, SP_MIN, SP_MAX)) begin
            state_next.night_sp = wdata_i;
          end
        end
        HR_ROLE_SEL: begin
          if (wdata_i <= 16'h0001) begin
            state_next.role_sel = wdata_i;
          end
        end
        HR_SRC_SEL: begin
          if (wdata_i <= 16'h0001) begin
            state_next.src_sel = wdata_i;
          end
        end
        HR_PWM_PERIOD: begin
          if (in_range(wdata_i, 16'h0001, PWM_MAX)) begin
            state_next.pwm_period = wdata_i;
          end
        end
        HR_CAL_LOW: begin
          if (wdata_i == CAL_TRIGGER) begin
            state_next.cal_low_go = 1'b1;
          end else if (wdata_i <= CAL_MAX) begin
            state_next.cal_low = wdata_i;
          end
        end
        HR_CAL_HIGH: begin
          if (wdata_i == CAL_TRIGGER) begin
            state_next.cal_high_go = 1'b1;
          end else if (wdata_i <= CAL_MAX) begin
            state_next.cal_high = wdata_i;
          end
        end
        HR_RO_EN: begin
          if (wdata_i <= 16'h0001) begin
            state_next.ro_en = wdata_i;
          end
        end
        HR_OVR_PCT: begin
          if (wdata_i <= PCT_MAX) begin
            state_next.ovr_pct = wdata_i;
          end
        end
        default: begin
          state_next.station = state_reg.station;
        end
      endcase
    end

    // Calibration results land whenever done is raised with a value up to CAL_MAX, triggered or not
    if (cal_low_done_i && (cal_low_value_i <= CAL_MAX)) begin
      state_next.cal_low = cal_low_value_i;
    end
    if (cal_high_done_i && (cal_high_value_i <= CAL_MAX)) begin
      state_next.cal_high = cal_high_value_i;
    end

    // Effective modes: bus registers in bus mode, jumpers otherwise
    state_next.bit_cycles = bit_cycles_of(state_reg.bit_rate);
    if (state_reg.bus_ctrl[0]) begin
      state_next.leader = state_reg.role_sel[0];
      state_next.int_src = state_reg.src_sel[0];
    end else begin
      state_next.leader = state_reg.pin_flt[PIN_ROLE];
      state_next.int_src = state_reg.pin_flt[PIN_SRC];
    end
    // Open contact with the function enabled means standby
    state_next.standby = state_reg.ro_en[0] && !state_reg.pin_flt[PIN_CONTACT];
    state_next.fault = board_link_fault_i;

    // Active setpoint selection
    if (!state_reg.int_src) begin
      state_next.act_sp = ext_setpoint_i;
    end else if (!state_reg.bus_ctrl[0]) begin
      state_next.act_sp = trim_setpoint_i;
    end else if (state_reg.pin_flt[PIN_NIGHT]) begin
      state_next.act_sp = state_reg.night_sp;
    end else begin
      state_next.act_sp = state_reg.day_sp;
    end

    // Output duty: standby, override, follower, leader, clamped to 100
    if (state_reg.standby) begin
      state_next.duty = 16'h0000;
    end else if (ovr_active) begin
      state_next.duty = state_reg.ovr_pct;
    end else if (!state_reg.leader) begin
      state_next.duty = (analog_in_pct_i > PCT_MAX) ? PCT_MAX : analog_in_pct_i;
    end else begin
      state_next.duty = (loop_duty_i > PCT_MAX) ? PCT_MAX : loop_duty_i;
    end

    // Read data, zero for reserved or unmapped addresses
    if (req_i && !we_i) begin
      if (space_i == SPACE_INPUT) begin
        case (addr_i)
          IR_MEAS_TEMP: state_next.rdata = meas_temp_i;
          IR_DUTY: state_next.rdata = state_reg.duty;
          IR_ACT_SP: state_next.rdata = state_reg.act_sp;
          IR_SRC_STAT: state_next.rdata = {15'h0000, state_reg.int_src};
          IR_ROLE_STAT: state_next.rdata = {15'h0000, state_reg.leader};
          IR_DAYNIGHT: state_next.rdata = {15'h0000, state_reg.pin_flt[PIN_NIGHT]};
          IR_REMOTE_OFF: state_next.rdata = {15'h0000, state_reg.standby};
          IR_LINK_FAULT: state_next.rdata = {15'h0000, state_reg.fault};
          default: state_next.rdata = 16'h0000;
        endcase
      end else begin
        case (addr_i)
          HR_STATION: state_next.rdata = state_reg.station;
          HR_BIT_RATE: state_next.rdata = state_reg.bit_rate;
          HR_PARITY: state_next.rdata = state_reg.parity;
          HR_DEV_TYPE: state_next.rdata = DEVICE_TYPE;
          HR_HW_REV: state_next.rdata = HW_REVISION;
          HR_FW_REV: state_next.rdata = FW_REVISION;
          HR_BUS_CTRL: state_next.rdata = state_reg.bus_ctrl;
          HR_OVR_EN: state_next.rdata = state_reg.ovr_en;
          HR_DAY_SP: state_next.rdata = state_reg.day_sp;
          HR_NIGHT_SP: state_next.rdata = state_reg.night_sp;
          HR_ROLE_SEL: state_next.rdata = state_reg.role_sel;
          HR_SRC_SEL: state_next.rdata = state_reg.src_sel;
          HR_PWM_PERIOD: state_next.rdata = state_reg.pwm_period;
          HR_CAL_LOW: state_next.rdata = state_reg.cal_low;
          HR_CAL_HIGH: state_next.rdata = state_reg.cal_high;
          HR_RO_EN: state_next.rdata = state_reg.ro_en;
          HR_OVR_PCT: state_next.rdata = state_reg.ovr_pct;
          default: state_next.rdata = 16'h0000;
        endcase
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.pin_s1 <= RST_PINS;
      state_reg.pin_s2 <= RST_PINS;
      state_reg.pin_s3 <= RST_PINS;
      state_reg.pin_flt <= RST_PINS;
      state_reg.station <= RST_STATION;
      state_reg.bit_rate <= RST_BIT_RATE;
      state_reg.parity <= RST_PARITY;
      state_reg.bus_ctrl <= RST_BUS_CTRL;
      state_reg.ovr_en <= RST_OVR_EN;
      state_reg.day_sp <= RST_DAY_SP;
      state_reg.night_sp <= RST_NIGHT_SP;
      state_reg.role_sel <= RST_ROLE_SEL;
      state_reg.src_sel <= RST_SRC_SEL;
      state_reg.pwm_period <= RST_PWM_PERIOD;
      state_reg.cal_low <= RST_CAL_LOW;
      state_reg.cal_high <= RST_CAL_HIGH;
      state_reg.ro_en <= RST_RO_EN;
      state_reg.ovr_pct <= RST_OVR_PCT;
      state_reg.bit_cycles <= BIT_CYC_2;
      state_reg.leader <= 1'b1;
      state_reg.int_src <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign ack_o = state_reg.ack;
  assign rdata_o = state_reg.rdata;
  assign station_addr_o = state_reg.station[7:0];
  assign bit_rate_code_o = state_reg.bit_rate[2:0];
  assign bit_cycles_o = state_reg.bit_cycles;
  assign parity_o = state_reg.parity[1:0];
  assign bus_mode_o = state_reg.bus_ctrl[0];
  assign leader_o = state_reg.leader;
  assign internal_setpoint_source_o = state_reg.int_src;
  assign standby_o = state_reg.standby;
  assign active_setpoint_o = state_reg.act_sp;
  assign duty_o = state_reg.duty[6:0];
  assign pwm_period_s_o = state_reg.pwm_period[5:0];
  assign cal_low_start_o = state_reg.cal_low_go;
  assign cal_high_start_o = state_reg.cal_high_go;
  assign cal_low_o = state_reg.cal_low[9:0];
  assign cal_high_o = state_reg.cal_high[9:0];

  // Checks
  a_duty_in_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.duty <= PCT_MAX) else $error("duty above 100");

  a_override_drives_duty: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ovr_active && !state_reg.standby) |=> (state_reg.duty == $past(state_reg.ovr_pct)))
    else $error("override value not driven");

  a_standby_zero_duty: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.standby |=> (duty_o == 7'h00)) else $error("duty nonzero in standby");

  a_rate_write_lands: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (hold_wr && addr_i == HR_BIT_RATE && wdata_i == 16'h0004)
    |=> ##1 (bit_cycles_o == BIT_CYC_4)) else $error("bit rate not applied");

  a_type_read_const: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (req_i && !we_i && space_i == SPACE_HOLD && addr_i == HR_DEV_TYPE)
    |=> (ack_o && rdata_o == DEVICE_TYPE)) else $error("device type changed");

  a_reserved_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (req_i && !we_i && space_i == SPACE_INPUT && addr_i == 16'h0005)
    |=> (rdata_o == 16'h0000)) else $error("reserved read nonzero");

  a_cal_trigger_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (hold_wr && addr_i == HR_CAL_LOW && wdata_i == CAL_TRIGGER && !cal_low_done_i)
    |=> (cal_low_start_o && $stable(state_reg.cal_low)) ##1 !cal_low_start_o)
    else $error("calibration trigger wrong");

  a_standalone_uses_pins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !state_reg.bus_ctrl[0] |=> (leader_o == $past(state_reg.pin_flt[PIN_ROLE])))
    else $error("standalone role not from jumper");

  a_setpoint_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    in_range(state_reg.day_sp, SP_MIN, SP_MAX) && in_range(state_reg.night_sp, SP_MIN, SP_MAX))
    else $error("setpoint out of range");

  a_fault_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    board_link_fault_i |=> state_reg.fault) else $error("link fault not flagged");

endmodule

// *** tb/modbus_master_model.sv ***
`timescale 1ns/10ps
module modbus_master_model (
  // Clock
  input wire logic sys_clk_i,
  // Requests towards the register bank
  output logic req_o,
  output logic space_o,
  output logic we_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  // Answers from the register bank
  input wire logic ack_i,
  input wire logic [15:0] rdata_i
);
  // Idle request lines at time zero
  initial begin
    req_o = 1'b0;
    {space_o, we_o, addr_o, wdata_o} = '0;
  end
  // One access: request for one cycle, answer awaited for a bounded time
  task automatic xfer(input logic sp, input logic wr, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] rd, output logic ok);
    ok = 1'b0;
    rd = 16'h0000;
    @(negedge sys_clk_i);
    {req_o, space_o, we_o, addr_o, wdata_o} = {1'b1, sp, wr, a, d};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge sys_clk_i);
      req_o = 1'b0;
      if (ack_i === 1'b1) begin
        rd = rdata_i;
        ok = 1'b1;
      end
    end
    // Released lines stop showing the last value
    {space_o, we_o, addr_o, wdata_o} = {~sp, 1'b0, ~a, ~d};
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  import heat_regs_pkg::*;
  // Identity values, arbitrary
  localparam logic [15:0] DEV_ID = 16'h1234;
  localparam logic [15:0] HW_ID = 16'h0102;
  localparam logic [15:0] FW_ID = 16'h0304;
  logic sys_clk_i, rst_n_i, req, space, we, ack, fault, low_done, high_done, rd_ok;
  logic night, contact, role_jmp, src_jmp, bus_mode, leader, int_src, standby, lo_st, hi_st;
  logic [15:0] addr, wdata, rdata, temp, loop_duty, analog, external_setpoint_source, trim_sp, lo_val, hi_val;
  logic [15:0] bit_cycles, act_sp, rd_data;
  logic [9:0] cal_low, cal_high;
  logic [6:0] duty;
  logic [5:0] pwm;
  logic [2:0] rate;
  logic [7:0] station;
  logic [1:0] parity;
  int num_errors = 0;
  int check_count = 0;
  int low_starts = 0;
  int high_starts = 0;
  // Device under test and the bus master in front of it
  heating_ctrl_modbus_regs #(.DEVICE_TYPE(DEV_ID), .HW_REVISION(HW_ID), .FW_REVISION(FW_ID))
    i_heating_ctrl_modbus_regs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .space_i(space), .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata),
    .meas_temp_i(temp), .loop_duty_i(loop_duty), .analog_in_pct_i(analog),
    .ext_setpoint_i(external_setpoint_source), .trim_setpoint_i(trim_sp), .board_link_fault_i(fault),
    .cal_low_done_i(low_done), .cal_low_value_i(lo_val), .cal_high_done_i(high_done),
    .cal_high_value_i(hi_val), .night_switch_i(night), .remote_off_contact_input_i(contact),
    .role_jumper_i(role_jmp), .source_jumper_i(src_jmp), .station_addr_o(station),
    .bit_rate_code_o(rate), .bit_cycles_o(bit_cycles), .parity_o(parity), .bus_mode_o(bus_mode),
    .leader_o(leader), .internal_setpoint_source_o(int_src), .standby_o(standby),
    .active_setpoint_o(act_sp), .duty_o(duty), .pwm_period_s_o(pwm), .cal_low_start_o(lo_st),
    .cal_high_start_o(hi_st), .cal_low_o(cal_low), .cal_high_o(cal_high));
  modbus_master_model i_modbus_master_model (.sys_clk_i(sys_clk_i), .req_o(req),
    .space_o(space), .we_o(we), .addr_o(addr), .wdata_o(wdata), .ack_i(ack), .rdata_i(rdata));
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Count calibration start pulses mid-cycle, where each pulse has settled
  always @(negedge sys_clk_i) begin
    if (lo_st === 1'b1) low_starts++;
    if (hi_st === 1'b1) high_starts++;
  end
  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic access(input logic sp, input logic w, input logic [15:0] a, input logic [15:0] d);
    i_modbus_master_model.xfer(sp, w, a, d, rd_data, rd_ok);
    if (rd_ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: ack %h expected %h", $time, rd_ok, 1'b1);
      print_verdict();
    end
  endtask
  task automatic rd(input logic sp, input logic [15:0] a, input logic [15:0] e);
    access(sp, 1'b0, a, 16'h0000);
    `CHK(rd_data, e)
  endtask
  // Write, then let the two-cycle lag of derived outputs pass
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    access(SPACE_HOLD, 1'b1, a, d);
    repeat (2) @(negedge sys_clk_i);
  endtask
  // Pins {night, contact, role, source}, then wait out the input filter
  task automatic pins(input logic [3:0] p);
    {night, contact, role_jmp, src_jmp} = p;
    repeat (6) @(negedge sys_clk_i);
  endtask
  // Status flags {source, role, day_night, remote_off, link_fault}
  task automatic status(input logic [4:0] e);
    rd(SPACE_INPUT, IR_SRC_STAT, {15'h0000, e[4]});
    rd(SPACE_INPUT, IR_ROLE_STAT, {15'h0000, e[3]});
    rd(SPACE_INPUT, IR_DAYNIGHT, {15'h0000, e[2]});
    rd(SPACE_INPUT, IR_REMOTE_OFF, {15'h0000, e[1]});
    rd(SPACE_INPUT, IR_LINK_FAULT, {15'h0000, e[0]});
  endtask
  task automatic t_reset();
    logic [15:0] t [14][2] = '{'{HR_STATION, 16'h0001}, '{HR_BIT_RATE, 16'h0002},
      '{HR_PARITY, 16'h0001}, '{HR_BUS_CTRL, 16'h0000}, '{HR_OVR_EN, 16'h0000},
      '{HR_DAY_SP, 16'h00FA}, '{HR_NIGHT_SP, 16'h00B4}, '{HR_ROLE_SEL, 16'h0001},
      '{HR_SRC_SEL, 16'h0001}, '{HR_PWM_PERIOD, 16'h001E}, '{HR_CAL_LOW, 16'h00D2},
      '{HR_CAL_HIGH, 16'h01EA}, '{HR_RO_EN, 16'h0001}, '{HR_OVR_PCT, 16'h0000}};
    for (int i = 0; i < 14; i++) begin
      rd(SPACE_HOLD, t[i][0], t[i][1]);
    end
    `CHK({bit_cycles, pwm}, {16'(CLK_HZ / 19200), 6'h1E})
    `CHK({cal_low, cal_high}, {10'h0D2, 10'h1EA})
    $display("test reset values done");
  endtask
  task automatic t_fixed();
    logic [15:0] hres [6] = '{16'h0009, 16'h000A, 16'h0013, 16'h0014, 16'h0016, 16'h001E};
    logic [15:0] ires [6] = '{16'h0004, 16'h0005, 16'h0009, 16'h000F, 16'h0012, 16'h0010};
    wr(HR_DEV_TYPE, 16'hFFFF);
    wr(HR_HW_REV, 16'hFFFF);
    wr(HR_FW_REV, 16'hFFFF);
    rd(SPACE_HOLD, HR_DEV_TYPE, DEV_ID);
    rd(SPACE_HOLD, HR_HW_REV, HW_ID);
    rd(SPACE_HOLD, HR_FW_REV, FW_ID);
    for (int i = 0; i < 6; i++) begin
      wr(hres[i], 16'h0001);
      rd(SPACE_HOLD, hres[i], 16'h0000);
      rd(SPACE_INPUT, ires[i], 16'h0000);
    end
    $display("test fixed and reserved done");
  endtask
  task automatic t_rates();
    int baud [4] = '{9600, 19200, 38400, 57600};
    for (int i = 0; i < 4; i++) begin
      wr(HR_BIT_RATE, 16'(i + 1));
      `CHK({rate, bit_cycles}, {3'(i + 1), 16'(CLK_HZ / baud[i])})
    end
    wr(HR_BIT_RATE, 16'h0005);
    wr(HR_BIT_RATE, 16'h0000);
    rd(SPACE_HOLD, HR_BIT_RATE, 16'h0004);
    wr(HR_BIT_RATE, 16'h0002);
    $display("test bit rates done");
  endtask
  task automatic t_status();
    fault = 1'b1;
    pins(4'b1000);
    status(5'b00111);
    rd(SPACE_INPUT, IR_DUTY, 16'h0000);
    rd(SPACE_INPUT, IR_ACT_SP, 16'h0096);
    wr(HR_RO_EN, 16'h0000);
    `CHK(standby, 1'b0)
    wr(HR_RO_EN, 16'h0001);
    fault = 1'b0;
    pins(4'b0111);
    status(5'b11000);
    rd(SPACE_INPUT, IR_DUTY, 16'h0064);
    rd(SPACE_INPUT, IR_ACT_SP, 16'h00D2);
    $display("test status done");
  endtask
  task automatic t_bus();
    loop_duty = 16'h0028;
    wr(HR_OVR_EN, 16'h0001);
    wr(HR_OVR_PCT, 16'h0037);
    rd(SPACE_HOLD, HR_OVR_EN, 16'h0001);
    `CHK(duty, 7'h28)
    wr(HR_BUS_CTRL, 16'h0001);
    `CHK({bus_mode, duty}, {1'b1, 7'h37})
    wr(HR_OVR_PCT, 16'h0065);
    rd(SPACE_INPUT, IR_DUTY, 16'h0037);
    wr(HR_OVR_EN, 16'h0000);
    wr(HR_ROLE_SEL, 16'h0000);
    `CHK({leader, duty}, {1'b0, 7'h64})
    wr(HR_DAY_SP, 16'h0032);
    wr(HR_NIGHT_SP, 16'h012C);
    wr(HR_DAY_SP, 16'h0031);
    wr(HR_NIGHT_SP, 16'h012D);
    `CHK(act_sp, 16'h0032)
    pins(4'b1111);
    rd(SPACE_INPUT, IR_ACT_SP, 16'h012C);
    wr(HR_SRC_SEL, 16'h0000);
    `CHK({int_src, act_sp}, {1'b0, 16'h0096})
    status(5'b00100);
    wr(HR_BUS_CTRL, 16'h0000);
    $display("test bus control done");
  endtask
  task automatic t_cal();
    wr(HR_CAL_LOW, 16'h0001);
    wr(HR_CAL_HIGH, 16'h0001);
    `CHK({low_starts, high_starts}, {32'sd1, 32'sd1})
    rd(SPACE_HOLD, HR_CAL_LOW, 16'h00D2);
    wr(HR_CAL_LOW, 16'h03FF);
    wr(HR_CAL_HIGH, 16'h0400);
    `CHK({cal_low, cal_high}, {10'h3FF, 10'h1EA})
    low_done = 1'b1;
    @(negedge sys_clk_i);
    low_done = 1'b0;
    rd(SPACE_HOLD, HR_CAL_LOW, 16'h0123);
    wr(HR_PWM_PERIOD, 16'h0000);
    rd(SPACE_HOLD, HR_PWM_PERIOD, 16'h001E);
    wr(HR_PWM_PERIOD, 16'h003C);
    wr(HR_PWM_PERIOD, 16'h003D);
    `CHK(pwm, 6'h3C)
    $display("test calibration and period done");
  endtask
  // Temperature word, input-space write refused, link settings, high calibration result
  task automatic t_link();
    rd(SPACE_INPUT, IR_MEAS_TEMP, 16'h00C8);
    access(SPACE_INPUT, 1'b1, HR_BIT_RATE, 16'h0004);
    rd(SPACE_HOLD, HR_BIT_RATE, 16'h0002);
    wr(HR_STATION, 16'h00F7);
    wr(HR_STATION, 16'h00F8);
    wr(HR_PARITY, 16'h0002);
    wr(HR_PARITY, 16'h0003);
    `CHK({station, parity}, {8'hF7, 2'h2})
    {hi_val, high_done} = {16'h0234, 1'b1};
    @(negedge sys_clk_i);
    {hi_val, high_done} = {16'h0400, 1'b1};
    @(negedge sys_clk_i);
    high_done = 1'b0;
    rd(SPACE_HOLD, HR_CAL_HIGH, 16'h0234);
    `CHK(cal_high, 10'h234)
    $display("test link settings done");
  endtask
  // Reset, then the scenarios
  initial begin
    rst_n_i = 1'b0;
    {temp, external_setpoint_source, trim_sp, loop_duty} = {16'h00C8, 16'h0096, 16'h00D2, 16'h0096};
    {analog, lo_val, hi_val} = {16'h0078, 16'h0123, 16'h0234};
    {fault, low_done, high_done} = 3'h0;
    {night, contact, role_jmp, src_jmp} = 4'h7;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_fixed();
    t_rates();
    t_status();
    t_bus();
    t_cal();
    t_link();
    print_verdict();
  end
endmodule
